// *** common/midmux_pkg.sv ***
`default_nettype none
package midmux_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_SUBSYS_STATUS = 8'h00;
    localparam logic [7:0] OFF_SYS_CONFIG    = 8'h04;
    localparam logic [7:0] OFF_EXT_SYS_CTL1  = 8'h08;
    localparam logic [7:0] OFF_EXT_DAC_CTL   = 8'h0c;
    localparam logic [7:0] OFF_CURSOR_MODE   = 8'h10;
    localparam logic [7:0] OFF_PIN_CTL       = 8'h14;
    // host register identities
    localparam logic [15:0] IO_SUBSYS_STATUS = 16'h42e8;
    localparam logic [7:0]  IDX_SYS_CONFIG   = 8'h40;
    localparam logic [7:0]  IDX_CURSOR_MODE  = 8'h45;
    localparam logic [7:0]  IDX_EXT_SYS_CTL1 = 8'h50;
    localparam logic [7:0]  IDX_EXT_DAC_CTL  = 8'h55;
    // field positions
    localparam int BIT_ID2_STATUS  = 6;
    localparam int BIT_ID1_STATUS  = 5;
    localparam int BIT_ID0_STATUS  = 4;
    localparam int BIT_SYSCFG_ALT  = 1;
    localparam int BIT_EXTSYS_BUS  = 2;
    localparam int BIT_DAC_EXT     = 5;
    localparam int BIT_DAC_GPORT   = 2;
    localparam int BIT_CURSOR_EXT  = 5;
    localparam int BIT_PIN_BLANK_N = 0;
    localparam int BIT_PIN_CUR0    = 1;
    localparam int BIT_PIN_ODDF    = 2;
    localparam int BIT_PIN_DISP_EN = 3;
    localparam int BIT_PIN_RDSTB_N = 4;
    localparam int BIT_PIN_BUS_REQ = 5;
    // reset values
    localparam logic [7:0] RST_CTL     = 8'h00;
    localparam logic [7:0] RST_PIN_CTL = 8'h11;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : midmux_pkg
`default_nettype wire

// *** hw/midmux_top.sv ***
`default_nettype none
module midmux_top
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // shared monitor id pins
    input  wire logic        monitor_id_bit2,
    input  wire logic        monitor_id_bit1,
    input  wire logic        monitor_id_bit0,
    // pin outputs and enables
    output logic             id2_out,
    output logic             id2_oe,
    output logic             id1_out,
    output logic             id1_oe,
    output logic             id0_out,
    output logic             id0_oe,
    output logic             odd_frame_out,
    output logic             odd_frame_oe,
    output logic             video_blank_n,
    // alternate function taps
    output logic             bus_grant_in,
    output logic             general_input_read_strobe_en
);
    typedef struct packed {
        // id synchronisers and status latch
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  id_latch;
        // host configuration registers
        logic [7:0]  sys_config;
        logic [7:0]  ext_sys_ctl1;
        logic [7:0]  ext_dac_ctl;
        logic [7:0]  cursor_mode;
        logic [7:0]  pin_ctl;
        // write channel
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        awready;
        logic        wready;
        // read channel
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // pin drives
        logic        id2_out;
        logic        id2_oe;
        logic        id1_out;
        logic        id1_oe;
        logic        id0_out;
        logic        id0_oe;
        logic        oddf_out;
        logic        oddf_oe;
        logic        blank_n;
        logic        grant;
        logic        rd_strobe_en;
    } midmux_state_t;

    // current and next state
    midmux_state_t st;
    midmux_state_t next_st;

    logic alt_mode;
    logic dac_ext;
    logic cur_ext;
    logic bus_en;
    logic gport;
    logic wr_fire;
    logic req_mode;
    logic strobe_mode;
    logic grant_mode;
    logic disp_mode;

    // raw configuration bits
    assign alt_mode = st.sys_config[midmux_pkg::BIT_SYSCFG_ALT];
    assign dac_ext  = st.ext_dac_ctl[midmux_pkg::BIT_DAC_EXT];
    assign cur_ext  = st.cursor_mode[midmux_pkg::BIT_CURSOR_EXT];
    assign bus_en   = st.ext_sys_ctl1[midmux_pkg::BIT_EXTSYS_BUS];
    assign gport    = st.ext_dac_ctl[midmux_pkg::BIT_DAC_GPORT];

    // pin function decode; strobe mode owns id0 before grant does
    assign req_mode    = alt_mode && bus_en;
    assign strobe_mode = alt_mode && dac_ext;
    assign grant_mode  = alt_mode && !gport && bus_en && !dac_ext;
    assign disp_mode   = dac_ext && cur_ext;

    // write fires once both halves are held and no response waits
    assign wr_fire  = st.aw_held && st.w_held && !st.bvalid;

    // next-state logic
    always_comb
    begin
        // hold everything unless a rule below changes it
        next_st = st;
        // two-flop sync
        // pins are asynchronous to the core; two stages tame metastability
        next_st.sync1 = {monitor_id_bit2, monitor_id_bit1, monitor_id_bit0};
        next_st.sync2 = st.sync1;
        // the id2 latch holds its last level while id2 drives; the id1 and id0 latches hold whenever alt_mode is set
        // latch id2 level
        if (!dac_ext)
        begin
            next_st.id_latch[2] = st.sync2[2];
        end
        if (!alt_mode)
        begin
            next_st.id_latch[1] = st.sync2[1];
        end
        if (!alt_mode)
        begin
            next_st.id_latch[0] = st.sync2[0];
        end

        next_st.id2_oe = dac_ext;
        if (cur_ext)
        begin
            next_st.id2_out = st.pin_ctl[midmux_pkg::BIT_PIN_DISP_EN];
        end
        else
        begin
            next_st.id2_out = st.pin_ctl[midmux_pkg::BIT_PIN_CUR0];
        end
        next_st.id1_oe  = req_mode;
        next_st.id1_out = st.pin_ctl[midmux_pkg::BIT_PIN_BUS_REQ];
        next_st.id0_oe       = strobe_mode;
        next_st.id0_out      = st.pin_ctl[midmux_pkg::BIT_PIN_RDSTB_N];
        next_st.rd_strobe_en = strobe_mode;
        if (grant_mode)
        begin
            next_st.grant = st.sync2[0];
        end
        else
        begin
            next_st.grant = 1'b0;
        end
        next_st.oddf_oe  = disp_mode;
        next_st.oddf_out = st.pin_ctl[midmux_pkg::BIT_PIN_ODDF];
        // blank is active low; low turns the dac video off
        // blank drive
        next_st.blank_n = st.pin_ctl[midmux_pkg::BIT_PIN_BLANK_N];

        // each half is held until both are in, so they may arrive in any order
        // write address capture
        if (!st.aw_held && s_axi_awvalid)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        // write data capture
        if (!st.w_held && s_axi_wvalid)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        // commit the held write and raise the response
        if (wr_fire)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = midmux_pkg::RESP_OKAY;
            // only the low byte lane carries register bits
            if (st.w_strb[0])
            begin
                case (st.aw_addr)
                    midmux_pkg::OFF_SYS_CONFIG:   next_st.sys_config   = st.w_data[7:0];
                    midmux_pkg::OFF_EXT_SYS_CTL1: next_st.ext_sys_ctl1 = st.w_data[7:0];
                    midmux_pkg::OFF_EXT_DAC_CTL:  next_st.ext_dac_ctl  = st.w_data[7:0];
                    midmux_pkg::OFF_CURSOR_MODE:  next_st.cursor_mode  = st.w_data[7:0];
                    midmux_pkg::OFF_PIN_CTL:      next_st.pin_ctl      = st.w_data[7:0];
                    midmux_pkg::OFF_SUBSYS_STATUS: next_st.bresp       = midmux_pkg::RESP_OKAY;
                    default:                      next_st.bresp        = midmux_pkg::RESP_SLVERR;
                endcase
            end
        end
        // retire the write response
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        // ready flags mirror the empty slots, straight from flops
        next_st.awready = !next_st.aw_held;
        next_st.wready  = !next_st.w_held;

        // read channel
        // the answer is registered one cycle after the address is taken
        if (!st.rvalid && s_axi_arvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = midmux_pkg::RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                midmux_pkg::OFF_SUBSYS_STATUS:
                begin
                    // only the three id bits are defined; the rest reads zero
                    next_st.rdata[midmux_pkg::BIT_ID2_STATUS] = st.id_latch[2];
                    next_st.rdata[midmux_pkg::BIT_ID1_STATUS] = st.id_latch[1];
                    next_st.rdata[midmux_pkg::BIT_ID0_STATUS] = st.id_latch[0];
                end
                midmux_pkg::OFF_SYS_CONFIG:   next_st.rdata[7:0] = st.sys_config;
                midmux_pkg::OFF_EXT_SYS_CTL1: next_st.rdata[7:0] = st.ext_sys_ctl1;
                midmux_pkg::OFF_EXT_DAC_CTL:  next_st.rdata[7:0] = st.ext_dac_ctl;
                midmux_pkg::OFF_CURSOR_MODE:  next_st.rdata[7:0] = st.cursor_mode;
                midmux_pkg::OFF_PIN_CTL:      next_st.rdata[7:0] = st.pin_ctl;
                default:                      next_st.rresp      = midmux_pkg::RESP_SLVERR;
            endcase
        end
        else if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        // a new read is taken only while no answer stands
        next_st.arready = !next_st.rvalid;
    end

    // state register
    // whole state in one register; reset puts the pins at their idle levels
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st              <= '0;
            st.sys_config   <= midmux_pkg::RST_CTL;
            st.ext_sys_ctl1 <= midmux_pkg::RST_CTL;
            st.ext_dac_ctl  <= midmux_pkg::RST_CTL;
            st.cursor_mode  <= midmux_pkg::RST_CTL;
            st.pin_ctl      <= midmux_pkg::RST_PIN_CTL;
            // undriven id pins read high, so the sync chain starts at ones
            st.sync1        <= 3'h7;
            st.sync2        <= 3'h7;
            st.id_latch     <= 3'h7;
            // active-low strobe and blank idle high
            st.id0_out      <= 1'b1;
            st.blank_n      <= 1'b1;
            // every channel is ready for its first request
            st.awready      <= 1'b1;
            st.wready       <= 1'b1;
            st.arready      <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // bus outputs straight from flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // pin outputs straight from flops
    assign id2_out       = st.id2_out;
    assign id2_oe        = st.id2_oe;
    assign id1_out       = st.id1_out;
    assign id1_oe        = st.id1_oe;
    assign id0_out       = st.id0_out;
    assign id0_oe        = st.id0_oe;
    assign odd_frame_out = st.oddf_out;
    assign odd_frame_oe  = st.oddf_oe;
    assign video_blank_n = st.blank_n;
    assign bus_grant_in  = st.grant;
    assign general_input_read_strobe_en = st.rd_strobe_en;
endmodule : midmux_top
`default_nettype wire

// *** dv/midmux_checker.sv ***
`default_nettype none
module midmux_checker
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // read channel
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pin functions
    input wire logic        monitor_id_bit0,
    input wire logic        id2_oe,
    input wire logic        id0_oe,
    input wire logic        odd_frame_oe,
    input wire logic        bus_grant_in,
    input wire logic        general_input_read_strobe_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_odd_needs_id2: assert property (odd_frame_oe |-> id2_oe)
        else $error("odd frame drive without id2 drive");
    chk_strobe_id0_oe: assert property (general_input_read_strobe_en == id0_oe)
        else $error("strobe mode and id0 drive disagree");
    chk_grant_excl: assert property (bus_grant_in |-> !id0_oe && !general_input_read_strobe_en)
        else $error("grant seen while id0 is an output");
    chk_grant_pin_high: assert property ($rose(bus_grant_in) |-> $past(monitor_id_bit0, 3))
        else $error("grant rose while id0 pin low");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_read_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not cleared");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule : midmux_checker
bind midmux_top midmux_checker chk_i (.core_clk, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .monitor_id_bit0, .id2_oe, .id0_oe, .odd_frame_oe, .bus_grant_in,
    .general_input_read_strobe_en);
`default_nettype wire

// *** dv/midmux_partner.sv ***
`default_nettype none
module midmux_partner
(
    // id wires
    output logic       [2:0] pin_lvl,
    input  wire logic  [2:0] blk_out,
    input  wire logic  [2:0] blk_oe,
    // monitor side
    input  wire logic  [2:0] mon_lvl,
    input  wire logic  [2:0] mon_en,
    // video dac side
    input  wire logic        blank_n,
    input  wire logic        disp_en,
    output logic             dac_on
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pin_lvl = (blk_oe & blk_out) | (~blk_oe & mon_en & mon_lvl) | (~blk_oe & ~mon_en);
    assign dac_on = blank_n & disp_en;
endmodule : midmux_partner
`default_nettype wire

// *** dv/test_monitor_id_and_dac_ctrl_pin_mux.sv ***
`default_nettype none
module test_monitor_id_and_dac_ctrl_pin_mux;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, resetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  pin_lvl, mon_lvl = 3'h0, mon_en = 3'h0;
    logic        id2_out, id2_oe, id1_out, id1_oe, id0_out, id0_oe, odd_frame_out, odd_frame_oe;
    logic        video_blank_n, bus_grant_in, general_input_read_strobe_en, dac_on;
    logic [4:0]  m;
    logic [7:0]  pv [4] = '{8'h00, 8'h3f, 8'h15, 8'h2a};
    int          error_cnt = 0, checks_done = 0;
    midmux_top dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .monitor_id_bit2(pin_lvl[2]), .monitor_id_bit1(pin_lvl[1]),
        .monitor_id_bit0(pin_lvl[0]), .id2_out, .id2_oe, .id1_out, .id1_oe, .id0_out, .id0_oe,
        .odd_frame_out, .odd_frame_oe, .video_blank_n, .bus_grant_in, .general_input_read_strobe_en);
    midmux_partner far (.pin_lvl, .blk_out({id2_out, id1_out, id0_out}), .blk_oe({id2_oe, id1_oe, id0_oe}),
        .mon_lvl, .mon_en, .blank_n(video_blank_n), .disp_en(id2_out), .dac_on);
    // bus clock
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
        logic ta, tw, tb;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge core_clk);
            if (ta === 1'b1) s_axi_awvalid <= 1'b0;
            if (tw === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (tb !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    // read and compare the masked word and the response
    task automatic rchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] rsp;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge core_clk);
            if (ta === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (tr !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(d & msk, e);
        chk({30'h0, rsp}, {30'h0, er});
    endtask : rchk
    // watchdog
    initial
    begin
        repeat (6000) @(posedge core_clk);
        error_cnt++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        rchk(midmux_pkg::OFF_SUBSYS_STATUS, 32'h70, 32'h70, midmux_pkg::RESP_OKAY);
        rchk(midmux_pkg::OFF_PIN_CTL, 32'hffffffff, 32'h11, midmux_pkg::RESP_OKAY);
        mon_en <= 3'h7;
        for (int i = 0; i < 8; i++)
        begin
            mon_lvl <= 3'(i);
            repeat (6) @(posedge core_clk);
            rchk(midmux_pkg::OFF_SUBSYS_STATUS, 32'h70, {25'h0, 3'(i), 4'h0}, midmux_pkg::RESP_OKAY);
        end
        mon_en <= 3'h0;
        $display("test status latch done");
        for (int i = 0; i < 32; i++)
        begin
            m = 5'(i);
            wr(midmux_pkg::OFF_SYS_CONFIG, {30'h0, m[0], 1'b0}, r);
            wr(midmux_pkg::OFF_EXT_SYS_CTL1, {29'h0, m[1], 2'h0}, r);
            wr(midmux_pkg::OFF_EXT_DAC_CTL, {26'h0, m[2], 2'h0, m[3], 2'h0}, r);
            wr(midmux_pkg::OFF_CURSOR_MODE, {26'h0, m[4], 5'h0}, r);
            repeat (5) @(negedge core_clk);
            chk({26'h0, id2_oe, odd_frame_oe, id1_oe, id0_oe, general_input_read_strobe_en, bus_grant_in},
                {26'h0, m[2], m[2] & m[4], m[0] & m[1], m[0] & m[2], m[0] & m[2], m[0] & m[1] & ~m[3] & ~m[2]});
        end
        $display("test pin modes done");
        foreach (pv[k])
        begin
            wr(midmux_pkg::OFF_PIN_CTL, {24'h0, pv[k]}, r);
            repeat (2) @(negedge core_clk);
            chk({27'h0, id2_out, id1_out, id0_out, odd_frame_out, video_blank_n},
                {27'h0, pv[k][3], pv[k][5], pv[k][4], pv[k][2], pv[k][0]});
            chk({31'h0, dac_on}, {31'h0, pv[k][0] & pv[k][3]});
        end
        $display("test pin levels done");
        wr(midmux_pkg::OFF_CURSOR_MODE, 32'h0, r);
        wr(midmux_pkg::OFF_PIN_CTL, 32'h2, r);
        repeat (2) @(negedge core_clk);
        chk({31'h0, id2_out}, 32'h1);
        chk({31'h0, odd_frame_oe}, 32'h0);
        @(posedge core_clk);
        s_axi_wstrb <= 4'he;
        wr(midmux_pkg::OFF_PIN_CTL, 32'h11, r);
        s_axi_wstrb <= 4'hf;
        chk({30'h0, r}, {30'h0, midmux_pkg::RESP_OKAY});
        rchk(midmux_pkg::OFF_PIN_CTL, 32'hff, 32'h2, midmux_pkg::RESP_OKAY);
        $display("test cursor zero and lane done");
        wr(8'h3c, 32'h1, r);
        chk({30'h0, r}, {30'h0, midmux_pkg::RESP_SLVERR});
        rchk(8'h3c, 32'h0, 32'h0, midmux_pkg::RESP_SLVERR);
        $display("test unmapped done");
        summarize();
    end
endmodule : test_monitor_id_and_dac_ctrl_pin_mux
`default_nettype wire
